// *** bench/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import via_pkg::*;
    localparam int NSRC = 14;
    localparam int ACK = 10;
    typedef struct packed {logic [2:0] k; logic [33:0] v;} via_note_t;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    via_resp_t bresp, rresp;
    logic [NSRC-1:0] src_event;
    logic trap_event, trap_clear, instr_start, skip_active, return_from_irq_instr_exec, vis_exec, vec_rvalid, slow;
    logic [14:0] cur_pc, return_from_irq_instr_addr, vis_pc, push_addr, pc_load_addr, vec_fetch_addr, p;
    logic [15:0] vec_rdata;
    logic [15:0] lfsr_q = 16'hC6BA;
    logic ack_busy, stack_push, stack_pop, pc_load, vec_fetch, global_irq_enable, trap_pending_flag;
    int n_fail = 0;
    int cmp_count = 0;
    via_note_t exp_q[$];

    via_top #(.NSRC(NSRC), .ACK_CLKS(ACK)) u_via_top (.*, .awprot(3'h0), .wstrb(4'hF), .arprot(3'h0));
    via_core_model u_via_core_model (.*);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] rom(input logic [14:0] a);
        return a[7:0] ^ 8'h3C;
    endfunction : rom

    function automatic logic [14:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q[14:0];
    endfunction : rnd

    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [36:0] seen, input logic [36:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic note(input logic [2:0] k, input logic [33:0] v);
        exp_q.push_back({k, v});
    endtask : note

    task automatic take(input logic [2:0] k, input logic [33:0] v);
        via_note_t n;
        n = exp_q.size() ? exp_q.pop_front() : '1;
        check("result", {k, v}, n);
    endtask : take

    // Outputs settle before the falling edge
    always @(negedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1) take(3'h0, {rresp, rdata});
        if (bvalid === 1'b1 && bready === 1'b1) take(3'h1, {bresp, 32'h0});
        if (stack_push === 1'b1) take(3'h2, {19'h0, push_addr});
        if (pc_load === 1'b1) take(3'h3, {19'h0, pc_load_addr});
        if (vec_fetch === 1'b1) take(3'h4, {19'h0, vec_fetch_addr});
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input via_resp_t r);
        logic aw_hs, w_hs, b_hs;
        note(3'h1, {r, 32'h0});
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end while (!b_hs);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        logic ar_hs, r_hs;
        note(3'h0, e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar_hs = arvalid && arready;
            r_hs = rvalid;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
        end while (!r_hs);
        rready <= 1'b0;
    endtask : rd

    task automatic start(input logic skip, input logic acked);
        logic [14:0] pc;
        pc = rnd();
        if (acked) note(3'h2, {19'h0, pc});
        if (acked) note(3'h3, {19'h0, 15'h00FF});
        @(posedge aclk);
        instr_start <= 1'b1;
        skip_active <= skip;
        cur_pc <= pc;
        @(posedge aclk);
        instr_start <= 1'b0;
        skip_active <= 1'b0;
        repeat (2) @(negedge aclk);
        check("ack_busy", {36'h0, ack_busy}, {36'h0, acked});
        repeat (ACK + 4) @(posedge aclk);
    endtask : start

    task automatic vector_select_instr(input logic [14:0] pc, input logic [3:0] slot);
        logic [14:0] fa;
        logic [15:0] ent;
        fa = {pc[14:8] + {6'h00, pc[7:0] == 8'hFF}, 8'hE0 + {3'h0, slot, 1'b0}};
        ent = {rom(fa), rom(fa + 15'h0001)};
        note(3'h4, {19'h0, fa});
        note(3'h3, {19'h0, ent[14:0]});
        @(posedge aclk);
        vis_exec <= 1'b1;
        vis_pc <= pc;
        slow <= lfsr_q[0];
        @(posedge aclk);
        vis_exec <= 1'b0;
        repeat (12) @(posedge aclk);
    endtask : vector_select_instr

    task automatic pulse(input int sel);
        @(posedge aclk);
        if (sel < NSRC) src_event[sel] <= 1'b1;
        trap_event <= (sel == 20);
        trap_clear <= (sel == 21);
        @(posedge aclk);
        src_event <= '0;
        trap_event <= 1'b0;
        trap_clear <= 1'b0;
    endtask : pulse

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, instr_start, skip_active} = '0;
        {return_from_irq_instr_exec, vis_exec, trap_event, trap_clear, slow} = '0;
        {awaddr, araddr, wdata, src_event} = '0;
        {cur_pc, return_from_irq_instr_addr, vis_pc} = '0;
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd(8'(i * 4), 34'h0);
        rd(8'h10, {2'b10, 32'h0});
        wr(8'h14, 32'h0, 2'b10);
        pulse(2);
        wr(8'h00, 32'h1, 2'b00);
        rd(8'h08, 34'h4);
        start(1'b0, 1'b0);
        pulse(5);
        wr(8'h08, 32'h20, 2'b00);
        wr(8'h04, 32'h24, 2'b00);
        start(1'b1, 1'b0);
        start(1'b0, 1'b1);
        rd(8'h00, 34'h0);
        pulse(9);
        wr(8'h04, 32'h224, 2'b00);
        p = rnd();
        vector_select_instr({p[14:8], 1'b0, p[6:0]}, 4'hA);
        wr(8'h08, 32'h200, 2'b00);
        p = rnd();
        vector_select_instr({p[14:8], 8'hFF}, 4'h3);
        p = rnd();
        note(3'h3, {19'h0, p});
        @(posedge aclk);
        return_from_irq_instr_exec <= 1'b1;
        return_from_irq_instr_addr <= p;
        @(posedge aclk);
        return_from_irq_instr_exec <= 1'b0;
        rd(8'h00, 34'h1);
        start(1'b0, 1'b1);
        wr(8'h00, 32'h1, 2'b00);
        start(1'b0, 1'b1);
        wr(8'h08, 32'h3FFF, 2'b00);
        p = rnd();
        vector_select_instr(p, 4'h0);
        pulse(20);
        rd(8'h00, 34'h2);
        start(1'b0, 1'b1);
        wr(8'h00, 32'h1, 2'b00);
        pulse(2);
        start(1'b0, 1'b0);
        p = rnd();
        vector_select_instr({p[14:8], 1'b1, p[6:0]}, 4'hF);
        pulse(21);
        rd(8'h00, 34'h1);
        start(1'b0, 1'b1);
        summarize();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        summarize();
    end
endmodule : testbench

bind via_top via_properties #(.ACK_CLKS(ACK_CLKS)) u_via_properties (.*);

// *** bench/via_core_model.sv ***
module via_core_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic vec_fetch,
    input wire logic [14:0] vec_fetch_addr,
    input wire logic slow,
    output logic vec_rvalid,
    output logic [15:0] vec_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [14:0] addr_q;
    logic [2:0] wait_q;
    logic busy_q;

    function automatic logic [7:0] rom(input logic [14:0] a);
        return a[7:0] ^ 8'h3C;
    endfunction : rom

    // Data toggles between reads
    always_ff @(posedge aclk) begin
        vec_rvalid <= 1'b0;
        vec_rdata <= ~vec_rdata;
        if (!aresetn) begin
            busy_q <= 1'b0;
            vec_rdata <= 16'h0000;
        end else if (vec_fetch) begin
            addr_q <= vec_fetch_addr;
            wait_q <= slow ? 3'h4 : 3'h0;
            busy_q <= 1'b1;
        end else if (busy_q && wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
        end else if (busy_q) begin
            busy_q <= 1'b0;
            vec_rvalid <= 1'b1;
            vec_rdata <= {rom(addr_q), rom(addr_q + 15'h0001)};
        end
    end
endmodule : via_core_model

// *** bench/via_properties.sv ***
module via_properties #(
    parameter int ACK_CLKS = 700
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic instr_start,
    input wire logic skip_active,
    input wire logic return_from_irq_instr_exec,
    input wire logic [14:0] return_from_irq_instr_addr,
    input wire logic vis_exec,
    input wire logic [14:0] vis_pc,
    input wire logic vec_rvalid,
    input wire logic [15:0] vec_rdata,
    input wire logic ack_busy,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic pc_load,
    input wire logic [14:0] pc_load_addr,
    input wire logic vec_fetch,
    input wire logic [14:0] vec_fetch_addr,
    input wire logic global_irq_enable,
    input wire logic trap_pending_flag,
    input wire logic trap_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ACK_MAX = ACK_CLKS + 4;
    logic [15:0] busy_len_q;
    logic out_q;
    wire [6:0] blk_w = vis_pc[14:8] + {6'h00, vis_pc[7:0] == 8'hFF};
    wire [14:0] vec_low_w = vec_rdata[14:0];

    always_ff @(posedge aclk) begin
        busy_len_q <= (!aresetn || !ack_busy) ? 16'h0000 : busy_len_q + 16'h0001;
        out_q <= aresetn && (vec_fetch || (out_q && !vec_rvalid));
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_ack_begin;
        $rose(ack_busy);
    endsequence
    sequence s_entry_jump;
        pc_load && pc_load_addr == 15'h00FF;
    endsequence

    property p_reset;
        disable iff (1'b0) !aresetn |=> !global_irq_enable && !trap_pending_flag;
    endproperty
    property p_cause;
        s_ack_begin |-> $past(instr_start) && !$past(skip_active)
            && ($past(global_irq_enable) || $past(trap_pending_flag));
    endproperty
    property p_gie_clr;
        s_ack_begin |=> !global_irq_enable;
    endproperty
    property p_push;
        s_ack_begin |-> ##[0:3] (stack_push && ack_busy);
    endproperty
    property p_entry;
        s_ack_begin |-> ##[1:ACK_MAX] s_entry_jump;
    endproperty
    property p_len;
        $fell(ack_busy) |-> busy_len_q == ACK_CLKS;
    endproperty
    property p_return_from_irq_instr;
        return_from_irq_instr_exec && !ack_busy && !instr_start |=> pc_load && stack_pop && global_irq_enable
            && pc_load_addr == $past(return_from_irq_instr_addr);
    endproperty
    property p_vis;
        vis_exec && !out_q && !vec_fetch |=> vec_fetch && vec_fetch_addr[7:5] == 3'h7
            && !vec_fetch_addr[0] && vec_fetch_addr[14:8] == $past(blk_w);
    endproperty
    property p_vec;
        vec_rvalid && !ack_busy && !return_from_irq_instr_exec |=> pc_load && pc_load_addr == $past(vec_low_w);
    endproperty
    property p_trap;
        trap_pending_flag && !trap_clear |=> trap_pending_flag;
    endproperty

    a_reset: assert property (p_reset) else $error("enables not cleared by reset");
    a_cause: assert property (p_cause) else $error("acknowledge without cause");
    a_gie_clr: assert property (p_gie_clr) else $error("global enable kept");
    a_push: assert property (p_push) else $error("no stack push");
    a_entry: assert property (p_entry) else $error("no jump to entry");
    a_len: assert property (p_len) else $error("acknowledge length wrong");
    a_return_from_irq_instr: assert property (p_return_from_irq_instr) else $error("return handling wrong");
    a_vis: assert property (p_vis) else $error("vector fetch address wrong");
    a_vec: assert property (p_vec) else $error("vector not loaded");
    a_trap: assert property (p_trap) else $error("trap flag lost");
endmodule : via_properties

// *** hdl/via_ack_seq.sv ***
`include "via_params.svh"

module via_ack_seq #(
    parameter int ACK_CLKS = 700
) (
    input wire logic aclk,
    input wire logic aresetn,
    via_link_if.seq lnk
);
    import via_pkg::*;

    via_seq_t st_q;
    via_seq_t st_d;
    logic [15:0] cnt_q;
    wire done = (cnt_q >= 16'(ACK_CLKS - 2));

    // ------------------------------------------------------------
    // Clear, push, wait, load entry
    // ------------------------------------------------------------
    // RULE9: seven instruction cycles
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            SEQ_IDLE: if (lnk.start) st_d = SEQ_CLR;
            SEQ_CLR: st_d = SEQ_PUSH;
            SEQ_PUSH: st_d = SEQ_WAIT;
            SEQ_WAIT: if (done) st_d = SEQ_JUMP;
            SEQ_JUMP: st_d = SEQ_IDLE;
            default: st_d = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= SEQ_IDLE;
            cnt_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            cnt_q <= (st_q == SEQ_IDLE) ? 16'h0000 : cnt_q + 16'h0001;
        end
    end

    assign lnk.busy = (st_q != SEQ_IDLE);
    assign lnk.clr = (st_q == SEQ_CLR);
    assign lnk.push = (st_q == SEQ_PUSH);
    assign lnk.jump = (st_q == SEQ_JUMP);

endmodule : via_ack_seq

// *** hdl/via_prio.sv ***
`include "via_params.svh"

module via_prio (
    via_link_if.arb lnk
);
    import via_pkg::*;

    // ------------------------------------------------------------
    // Highest set slot wins, slot 0 when none
    // ------------------------------------------------------------
    function automatic logic [3:0] top_slot(input logic [15:0] v);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 1; i < 16; i++) begin
            if (v[i]) begin
                s = 4'(i);
            end
        end
        return s;
    endfunction : top_slot

    // RULE22: even low byte
    assign lnk.slot = top_slot(lnk.active);
    assign lnk.low = `VIA_TABLE_BASE + {3'b000, lnk.slot, 1'b0};

endmodule : via_prio

// *** hdl/via_top.sv ***
// Behaviour
// RULE1: reset clears pending, enables, global enable
// RULE2: active means enabled and pending
// RULE3: enabling a pending source interrupts at once
// RULE4: software clears pending before enabling
// RULE5: acknowledge at normal instruction start only
// RULE6: acknowledgement clears global enable first
// RULE7: push address of next instruction
// RULE8: load program counter with entry location
// RULE9: acknowledgement lasts seven instruction cycles
// RULE10: software global enable write allows nesting
// RULE11: return sets enable, pops, reloads counter
// RULE12: pending requests taken right after return
// RULE13: service routine clears its pending early
// RULE14: vector select jumps through winner's entry
// RULE15: sixteen-entry table atop current block
// RULE16: select at block end uses next block
// RULE17: entry is 15 bits, high byte first
// RULE18: entries ranked upward, trap at top
// RULE19: highest ranked serviced first, next later
// RULE20: nothing active selects default entry
// RULE21: maskable needs enables and no trap
// RULE22: low byte E0 to FE replaces PC low
// RULE23: trap flag blocks all other interrupts
// RULE24: pending stays set until cleared

`include "via_params.svh"

module via_top #(
    parameter int NSRC = 14,
    parameter int ACK_CLKS = `VIA_ACK_ICYC *
        ((`VIA_ICYC_NS + `VIA_CLK_NS - 1) / `VIA_CLK_NS)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output via_pkg::via_resp_t bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output via_pkg::via_resp_t rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [NSRC-1:0] src_event,
    input wire logic trap_event,
    input wire logic trap_clear,
    input wire logic instr_start,
    input wire logic skip_active,
    input wire logic [14:0] cur_pc,
    input wire logic return_from_irq_instr_exec,
    input wire logic [14:0] return_from_irq_instr_addr,
    input wire logic vis_exec,
    input wire logic [14:0] vis_pc,
    input wire logic vec_rvalid,
    input wire logic [15:0] vec_rdata,
    output logic ack_busy,
    output logic stack_push,
    output logic [14:0] push_addr,
    output logic stack_pop,
    output logic pc_load,
    output logic [14:0] pc_load_addr,
    output logic vec_fetch,
    output logic [14:0] vec_fetch_addr,
    output logic global_irq_enable,
    output logic trap_pending_flag
);
    import via_pkg::*;

    localparam via_resp_t RESP_OK = 2'b00;
    localparam via_resp_t RESP_ERR = 2'b10;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic gie_q;
    logic [NSRC-1:0] en_q;
    logic [NSRC-1:0] pend_q;
    logic trap_q;
    logic trap_req_q;
    logic [14:0] ret_pc_q;
    logic [3:0] last_slot_q;
    logic vis_wait_q;

    logic aw_got_q;
    logic w_got_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    via_resp_t bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    via_resp_t rresp_q;

    logic push_q;
    logic [14:0] push_addr_q;
    logic pop_q;
    logic load_q;
    logic [14:0] load_addr_q;
    logic fetch_q;
    logic [14:0] fetch_addr_q;

    via_link_if lnk();

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : lane_mask

    // ------------------------------------------------------------
    // Request detection
    // ------------------------------------------------------------
    // RULE2: enabled and pending
    wire [NSRC-1:0] active = en_q & pend_q;
    wire [15:0] act_w = 16'(active);
    wire any_active = |active;
    wire normal_start = instr_start && !skip_active && !lnk.busy;
    // RULE21: global enable, no trap service
    // RULE23: trap flag inhibits maskable
    // RULE3: no fresh event needed
    wire mask_req = gie_q && any_active && !trap_q;
    // RULE5: skip done before acknowledge
    // RULE12: taken at first normal start
    wire ack_start = normal_start && (mask_req || trap_req_q);

    // ------------------------------------------------------------
    // Arbitration and sequencing
    // ------------------------------------------------------------
    // RULE18: slot 0 default, trap top
    // RULE19: highest ranked wins
    assign lnk.active = {trap_q, act_w[13:0], 1'b0};
    assign lnk.start = ack_start;

    via_prio u_prio (
        .lnk(lnk.arb)
    );

    via_ack_seq #(
        .ACK_CLKS(ACK_CLKS)
    ) u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .lnk(lnk.seq)
    );

    // RULE16: last byte uses next block
    wire block_end = (vis_pc[7:0] == 8'hFF);
    wire [6:0] tbl_hi = block_end ? 7'(vis_pc[14:8] + 7'h01) : vis_pc[14:8];
    // RULE15: table at block top
    // RULE22: low byte replaced
    wire [14:0] tbl_addr = {tbl_hi, lnk.low};

    // ------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------
    wire aw_hs = awvalid && awready;
    wire w_hs = wvalid && wready;
    wire ar_hs = arvalid && arready;
    wire wr_fire = aw_got_q && w_got_q && !bvalid_q;
    wire [31:0] wmask = lane_mask(w_strb_q);
    wire wr_ctrl = wr_fire && (aw_addr_q[7:2] == `VIA_OFF_CTRL >> 2);
    wire wr_en = wr_fire && (aw_addr_q[7:2] == `VIA_OFF_EN >> 2);
    wire wr_pend = wr_fire && (aw_addr_q[7:2] == `VIA_OFF_PEND >> 2);
    wire wr_stat = wr_fire && (aw_addr_q[7:2] == `VIA_OFF_STAT >> 2);
    wire wr_hit = wr_ctrl || wr_en || wr_pend || wr_stat;
    wire [NSRC-1:0] w_bits = NSRC'(w_data_q & wmask);
    wire [NSRC-1:0] w_keep = NSRC'(~wmask);
    wire gie_wr_en = wr_ctrl && w_strb_q[0];
    wire gie_wr_val = w_data_q[`VIA_CTRL_GIE_BIT];

    wire rd_ctrl = (araddr[7:2] == `VIA_OFF_CTRL >> 2);
    wire rd_en = (araddr[7:2] == `VIA_OFF_EN >> 2);
    wire rd_pend = (araddr[7:2] == `VIA_OFF_PEND >> 2);
    wire rd_stat = (araddr[7:2] == `VIA_OFF_STAT >> 2);
    wire rd_hit = rd_ctrl || rd_en || rd_pend || rd_stat;

    wire [31:0] ctrl_word = {30'h0000_0000, trap_q, gie_q};
    wire [31:0] stat_word = {23'h00_0000, lnk.busy, vis_wait_q, 3'b000, last_slot_q};
    wire [31:0] rd_word = rd_ctrl ? ctrl_word :
        rd_en ? 32'(en_q) :
        rd_pend ? 32'(pend_q) :
        rd_stat ? stat_word : 32'h0000_0000;

    assign awready = !aw_got_q && !bvalid_q;
    assign wready = !w_got_q && !bvalid_q;
    assign arready = !rvalid_q;

    // ------------------------------------------------------------
    // Bus channel registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OK;
        end else begin
            if (aw_hs) begin
                aw_got_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (w_hs) begin
                w_got_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? RESP_OK : RESP_ERR;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OK;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? RESP_OK : RESP_ERR;
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Enables and pending bits
    // ------------------------------------------------------------
    // RULE1: cleared on reset
    // RULE24: pending held, set wins
    // RULE4: software clears by writing one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_q <= NSRC'(`VIA_EN_RST);
            pend_q <= NSRC'(`VIA_PEND_RST);
        end else begin
            if (wr_en) begin
                en_q <= (en_q & w_keep) | w_bits;
            end
            pend_q <= (pend_q & ~(wr_pend ? w_bits : '0)) | src_event;
        end
    end

    // ------------------------------------------------------------
    // Global enable and trap flag
    // ------------------------------------------------------------
    // RULE1: cleared on reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gie_q <= `VIA_GIE_RST;
        end else if (lnk.clr) begin
            // RULE6: cleared on acknowledge
            gie_q <= 1'b0;
        end else if (return_from_irq_instr_exec) begin
            // RULE11: return sets enable
            gie_q <= 1'b1;
        end else if (gie_wr_en) begin
            // RULE10: software nesting enable
            gie_q <= gie_wr_val;
        end
    end

    // RULE23: only clear or reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trap_q <= 1'b0;
            trap_req_q <= 1'b0;
        end else begin
            trap_q <= trap_event || (trap_q && !trap_clear);
            trap_req_q <= trap_event || (trap_req_q && !ack_start);
        end
    end

    // ------------------------------------------------------------
    // Acknowledge, return and vector select
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ret_pc_q <= 15'h0000;
            push_q <= 1'b0;
            push_addr_q <= 15'h0000;
            pop_q <= 1'b0;
            load_q <= 1'b0;
            load_addr_q <= 15'h0000;
            fetch_q <= 1'b0;
            fetch_addr_q <= 15'h0000;
            vis_wait_q <= 1'b0;
            last_slot_q <= 4'h0;
        end else begin
            push_q <= 1'b0;
            pop_q <= 1'b0;
            load_q <= 1'b0;
            fetch_q <= 1'b0;
            if (ack_start) begin
                ret_pc_q <= cur_pc;
            end
            if (lnk.push) begin
                // RULE7: push next instruction address
                push_q <= 1'b1;
                push_addr_q <= ret_pc_q;
            end
            if (lnk.jump) begin
                // RULE8: jump to entry
                load_q <= 1'b1;
                load_addr_q <= `VIA_ENTRY_PC;
            end else if (return_from_irq_instr_exec) begin
                // RULE11: pop and reload
                pop_q <= 1'b1;
                load_q <= 1'b1;
                load_addr_q <= return_from_irq_instr_addr;
            end else if (vis_wait_q && vec_rvalid) begin
                // RULE17: high byte first
                load_q <= 1'b1;
                load_addr_q <= {vec_rdata[14:8], vec_rdata[7:0]};
                vis_wait_q <= 1'b0;
            end
            if (vis_exec && !vis_wait_q) begin
                // RULE14: winner picks entry
                // RULE20: default when none
                fetch_q <= 1'b1;
                fetch_addr_q <= tbl_addr;
                last_slot_q <= lnk.slot;
                vis_wait_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign ack_busy = lnk.busy;
    assign stack_push = push_q;
    assign push_addr = push_addr_q;
    assign stack_pop = pop_q;
    assign pc_load = load_q;
    assign pc_load_addr = load_addr_q;
    assign vec_fetch = fetch_q;
    assign vec_fetch_addr = fetch_addr_q;
    assign global_irq_enable = gie_q;
    assign trap_pending_flag = trap_q;

endmodule : via_top

// *** pkg/via_link_if.sv ***
interface via_link_if;
    logic [15:0] active;
    logic [3:0] slot;
    logic [7:0] low;
    logic start;
    logic busy;
    logic clr;
    logic push;
    logic jump;

    modport arb (input active, output slot, output low);
    modport seq (input start, output busy, output clr, output push, output jump);
    modport core (output active, input slot, input low, output start, input busy,
        input clr, input push, input jump);
endinterface : via_link_if

// *** pkg/via_params.svh ***
`ifndef VIA_PARAMS_SVH
`define VIA_PARAMS_SVH

// ------------------------------------------------------------
// Offsets, fields, vectors and timing
// ------------------------------------------------------------
`define VIA_OFF_CTRL 8'h00
`define VIA_OFF_EN 8'h04
`define VIA_OFF_PEND 8'h08
`define VIA_OFF_STAT 8'h0C
`define VIA_CTRL_GIE_BIT 0
`define VIA_CTRL_TRAP_BIT 1
`define VIA_STAT_BUSY_BIT 8
`define VIA_GIE_RST 1'b0
`define VIA_EN_RST 16'h0000
`define VIA_PEND_RST 16'h0000
`define VIA_ENTRY_PC 15'h00FF
`define VIA_TABLE_BASE 8'hE0
`define VIA_TRAP_SLOT 4'hF
`define VIA_CLK_NS 10
`define VIA_ICYC_NS 1000
`define VIA_ACK_ICYC 7

`endif

// *** pkg/via_pkg.sv ***
package via_pkg;

    typedef logic [1:0] via_resp_t;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_CLR = 3'b001,
        SEQ_PUSH = 3'b011,
        SEQ_WAIT = 3'b010,
        SEQ_JUMP = 3'b110
    } via_seq_t;

endpackage : via_pkg
